//--- hdl/wdtu_defs.svh
// Behaviour
// - count on a nominal 1 ms tick standing in for the 31 kHz low-frequency oscillator
// - mode 00 keeps the watchdog off whatever the enable bit or sleep state
// - mode 11 keeps the watchdog active always, sleep included, enable bit ignored
// - mode 10 keeps the watchdog active while awake, off while asleep
// - mode 01 follows the software enable bit, independent of sleep
// - software period select sets the time-out from 1 ms to 256 s
// - after any reset the period select gives a 2 s time-out
// - counter clears on reset, clear instruction, oscillator failure and disabling
// - counter clears on sleep entry, then counts from zero if still enabled
// - counter clears on sleep exit and stays clear while oscillator start-up runs
// - time-out in sleep wakes the core, sets expired flag, no reset
// - changing the internal oscillator divider leaves the counter alone
`ifndef WDTU_DEFS_SVH
`define WDTU_DEFS_SVH

`define WDTU_ADDR_W          8
`define WDTU_DATA_W          8
`define WDTU_OFS_CTRL        8'h00
`define WDTU_OFS_STAT        8'h04

`define WDTU_CTRL_EN_BIT     0
`define WDTU_CTRL_PS_LSB     1
`define WDTU_CTRL_PS_W       5
`define WDTU_CTRL_PS_RST     5'h0b
`define WDTU_CTRL_EN_RST     1'b0
`define WDTU_PS_MAX          5'h12

`define WDTU_STAT_EXP_BIT    0
`define WDTU_STAT_SLP_BIT    1
`define WDTU_STAT_ACT_BIT    2

`define WDTU_LFOSC_KHZ       31
`define WDTU_TICK_NS         1000000
`define WDTU_CLK_NS          10
`define WDTU_TICK_CYCLES     (`WDTU_TICK_NS / `WDTU_CLK_NS)
`define WDTU_MS_CNT_W        18

`endif

//--- hdl/wdtu_pkg.sv
package wdtu_pkg;

    typedef enum logic [1:0] {
        WDTU_MODE_OFF   = 2'b00,
        WDTU_MODE_SW    = 2'b01,
        WDTU_MODE_AWAKE = 2'b10,
        WDTU_MODE_ON    = 2'b11
    } wdtu_mode_t;

    typedef enum logic [1:0] {
        WDTU_ST_AWAKE  = 2'b00,
        WDTU_ST_ASLEEP = 2'b01,
        WDTU_ST_WAKING = 2'b10
    } wdtu_state_t;

endpackage : wdtu_pkg

//--- hdl/wdtu_tick_if.sv
`timescale 1ns/10ps
interface wdtu_tick_if;
    logic clear;
    logic tick;

    modport gen  (input clear, output tick);
    modport user (output clear, input tick);
endinterface : wdtu_tick_if

//--- hdl/wdtu_tick_gen.sv
`timescale 1ns/10ps
`include "wdtu_defs.svh"
module wdtu_tick_gen #(
    parameter int unsigned TICK_CYCLES = `WDTU_TICK_CYCLES,
    parameter int unsigned CNT_W       = 17
) (
    input  wire logic  clock_i,
    input  wire logic  rst_b_i,
    wdtu_tick_if.gen   tk
);
    if (TICK_CYCLES < 2 || TICK_CYCLES > (64'd1 << CNT_W)) begin : g_bad_cycles
        $error("wdtu_tick_gen: TICK_CYCLES does not fit the divider");
    end

    localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] div_q;
    logic [CNT_W-1:0] div_d;
    logic             tick_q;
    logic             tick_d;

    // clearing restarts the whole millisecond so a fresh period is never short
    always_comb begin
        div_d  = div_q;
        tick_d = 1'b0;
        if (tk.clear) begin
            div_d = '0;
        end else if (div_q == LAST) begin
            div_d  = '0;
            tick_d = 1'b1;
        end else begin
            div_d = div_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule : wdtu_tick_gen

//--- hdl/wdtu_watchdog.sv
`timescale 1ns/10ps
`include "wdtu_defs.svh"
module wdtu_watchdog
    import wdtu_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `WDTU_TICK_CYCLES
) (
    input  wire logic                    clock_i,
    input  wire logic                    rst_b_i,
    // register port
    input  wire logic [`WDTU_ADDR_W-1:0] addr_i,
    input  wire logic [`WDTU_DATA_W-1:0] wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [`WDTU_DATA_W-1:0] rdata_o,
    // configuration and core status
    input  wire logic [1:0]              wdt_mode_cfg_i,
    input  wire logic                    sleep_i,
    input  wire logic                    clear_watchdog_instr_i,
    input  wire logic                    osc_fail_i,
    input  wire logic                    osc_startup_timer_i,
    // results
    output logic                         wdt_reset_o,
    output logic                         wake_o,
    output logic                         wdt_expired_flag_o,
    output logic                         sleep_entered_flag_o,
    output logic                         wdt_active_o
);
    localparam int PS_W  = `WDTU_CTRL_PS_W;
    localparam int CNT_W = `WDTU_MS_CNT_W;

    wdtu_tick_if tk ();

    wdtu_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES),
        .CNT_W       (17)
    ) u_tick (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .tk      (tk)
    );

    // control register
    logic            sw_wdt_enable_q;
    logic            sw_wdt_enable_d;
    logic [PS_W-1:0] wdt_period_select_q;
    logic [PS_W-1:0] wdt_period_select_d;

    always_comb begin
        sw_wdt_enable_d     = sw_wdt_enable_q;
        wdt_period_select_d = wdt_period_select_q;
        if (wr_i && addr_i == `WDTU_OFS_CTRL) begin
            sw_wdt_enable_d     = wdata_i[`WDTU_CTRL_EN_BIT];
            wdt_period_select_d = wdata_i[`WDTU_CTRL_PS_LSB +: PS_W];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            sw_wdt_enable_q     <= `WDTU_CTRL_EN_RST;
            wdt_period_select_q <= `WDTU_CTRL_PS_RST;
        end else begin
            sw_wdt_enable_q     <= sw_wdt_enable_d;
            wdt_period_select_q <= wdt_period_select_d;
        end
    end

    // sleep tracking
    wdtu_state_t state_q;
    wdtu_state_t state_d;
    logic        sleep_edge;

    always_comb begin
        state_d    = state_q;
        sleep_edge = 1'b0;
        case (state_q)
            WDTU_ST_AWAKE: begin
                if (sleep_i) begin
                    state_d    = WDTU_ST_ASLEEP;
                    sleep_edge = 1'b1;
                end
            end
            WDTU_ST_ASLEEP: begin
                if (!sleep_i) begin
                    sleep_edge = 1'b1;
                    state_d    = osc_startup_timer_i ? WDTU_ST_WAKING : WDTU_ST_AWAKE;
                end
            end
            WDTU_ST_WAKING: begin
                if (!osc_startup_timer_i) begin
                    state_d = WDTU_ST_AWAKE;
                end
            end
            default: begin
                state_d = WDTU_ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state_q <= WDTU_ST_AWAKE;
        end else begin
            state_q <= state_d;
        end
    end

    // mode decode
    wdtu_mode_t mode;
    logic       in_sleep;
    logic       active;

    assign mode     = wdtu_mode_t'(wdt_mode_cfg_i);
    assign in_sleep = (state_q == WDTU_ST_ASLEEP);

    always_comb begin
        case (mode)
            WDTU_MODE_OFF:   active = 1'b0;
            WDTU_MODE_SW:    active = sw_wdt_enable_q;
            WDTU_MODE_AWAKE: active = !in_sleep;
            WDTU_MODE_ON:    active = 1'b1;
            default:         active = 1'b0;
        endcase
    end

    // millisecond counter; the internal oscillator divider has no path in here
    logic [CNT_W-1:0] ms_cnt_q;
    logic [CNT_W-1:0] ms_cnt_d;
    logic [CNT_W-1:0] limit;
    logic [PS_W-1:0]  ps_eff;
    logic             clear_all;
    logic             timeout;

    // codes above the top step saturate at 256 s
    assign ps_eff = (wdt_period_select_q > `WDTU_PS_MAX) ? `WDTU_PS_MAX : wdt_period_select_q;
    assign limit  = (CNT_W'(1) << ps_eff) - CNT_W'(1);

    // holding clear while start-up runs covers both sleep exit and waking state
    assign clear_all = !active || clear_watchdog_instr_i || osc_fail_i || sleep_edge
                       || (state_q == WDTU_ST_WAKING) || osc_startup_timer_i;

    // at or above the limit: a shorter period chosen mid-count still expires
    assign timeout = !clear_all && tk.tick && (ms_cnt_q >= limit);

    assign tk.clear = clear_all;

    always_comb begin
        ms_cnt_d = ms_cnt_q;
        if (clear_all || timeout) begin
            ms_cnt_d = '0;
        end else if (tk.tick) begin
            ms_cnt_d = ms_cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_d;
        end
    end

    // events and status flags
    logic wdt_reset_q;
    logic wdt_reset_d;
    logic wake_q;
    logic wake_d;
    logic exp_flag_q;
    logic exp_flag_d;
    logic slp_flag_q;
    logic slp_flag_d;
    logic active_q;

    always_comb begin
        wdt_reset_d = timeout && !in_sleep;
        wake_d      = timeout && in_sleep;
        exp_flag_d  = exp_flag_q;
        slp_flag_d  = slp_flag_q;
        // the clear instruction drops both flags, but a same-cycle sleep entry still sets the sleep flag; the clear blocks any time-out
        if (clear_watchdog_instr_i) begin
            exp_flag_d = 1'b0;
            slp_flag_d = 1'b0;
        end
        if (timeout) begin
            exp_flag_d = 1'b1;
        end
        if (sleep_edge && state_q == WDTU_ST_AWAKE) begin
            slp_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            wdt_reset_q <= 1'b0;
            wake_q      <= 1'b0;
            exp_flag_q  <= 1'b0;
            slp_flag_q  <= 1'b0;
            active_q    <= 1'b0;
        end else begin
            wdt_reset_q <= wdt_reset_d;
            wake_q      <= wake_d;
            exp_flag_q  <= exp_flag_d;
            slp_flag_q  <= slp_flag_d;
            active_q    <= active;
        end
    end

    // read port: data only in the cycle after the strobe
    logic [`WDTU_DATA_W-1:0] rdata_q;
    logic [`WDTU_DATA_W-1:0] rdata_d;

    always_comb begin
        rdata_d = '0;
        if (rd_i) begin
            case (addr_i)
                `WDTU_OFS_CTRL: begin
                    rdata_d[`WDTU_CTRL_EN_BIT]           = sw_wdt_enable_q;
                    rdata_d[`WDTU_CTRL_PS_LSB +: PS_W]   = wdt_period_select_q;
                end
                `WDTU_OFS_STAT: begin
                    rdata_d[`WDTU_STAT_EXP_BIT] = exp_flag_q;
                    rdata_d[`WDTU_STAT_SLP_BIT] = slp_flag_q;
                    rdata_d[`WDTU_STAT_ACT_BIT] = active_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o              = rdata_q;
    assign wdt_reset_o          = wdt_reset_q;
    assign wake_o               = wake_q;
    assign wdt_expired_flag_o   = exp_flag_q;
    assign sleep_entered_flag_o = slp_flag_q;
    assign wdt_active_o         = active_q;
endmodule : wdtu_watchdog

//--- tb/wdtu_properties.sv
`timescale 1ns/10ps
module wdtu_checker #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic       clock_i,
    input wire logic       rst_b_i,
    input wire logic [1:0] wdt_mode_cfg_i,
    input wire logic       sleep_i,
    input wire logic       clear_watchdog_instr_i,
    input wire logic       osc_fail_i,
    input wire logic       osc_startup_timer_i,
    input wire logic       wdt_reset_o,
    input wire logic       wake_o,
    input wire logic       wdt_expired_flag_o,
    input wire logic       wdt_active_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    wire logic quiet = !wdt_reset_o && !wake_o;

    awake_reset_a: assert property (wdt_reset_o |-> !$past(sleep_i))
        else $error("reset pulse came while asleep");
    sleep_wake_a: assert property (wake_o |-> $past(sleep_i))
        else $error("wake pulse came while awake");
    expired_flag_a: assert property (wdt_reset_o || wake_o |-> wdt_expired_flag_o)
        else $error("time-out without expired flag");
    off_mode_a: assert property ((wdt_mode_cfg_i == 2'h0) [*3] |=> quiet)
        else $error("time-out with watchdog off");
    always_on_a: assert property ((wdt_mode_cfg_i == 2'h3) [*3] |-> wdt_active_o)
        else $error("always-on mode not active");
    sleep_off_a: assert property ((wdt_mode_cfg_i == 2'h2 && sleep_i) [*3] |=> quiet)
        else $error("awake-only mode timed out in sleep");
    clear_hold_a: assert property (clear_watchdog_instr_i |=> quiet [*3])
        else $error("time-out too soon after clear");
    osc_fail_a: assert property (osc_fail_i |=> quiet)
        else $error("time-out during oscillator failure");
    startup_hold_a: assert property (osc_startup_timer_i |=> quiet)
        else $error("time-out during oscillator start-up");

    cover property (wdt_reset_o);
    cover property (wake_o);
    cover property (osc_startup_timer_i ##1 !osc_startup_timer_i);
endmodule : wdtu_checker

bind wdtu_watchdog wdtu_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clock_i, .rst_b_i,
    .wdt_mode_cfg_i, .sleep_i, .clear_watchdog_instr_i, .osc_fail_i, .osc_startup_timer_i,
    .wdt_reset_o, .wake_o, .wdt_expired_flag_o, .wdt_active_o);

//--- tb/wdtu_core_model.sv
`timescale 1ns/10ps
module wdtu_core_model #(
    parameter int unsigned OST_CYC = 20
) (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic nap_i,
    input  wire logic wake_i,
    output logic      sleep_o,
    output logic      ost_o
);
    logic       sleep_q, sleep_d, nap_q;
    logic [5:0] ost_q, ost_d;
    always_comb begin
        sleep_d = sleep_q;
        ost_d = (ost_q != 6'h00) ? ost_q - 6'h01 : ost_q;
        if (nap_i && !nap_q) begin
            sleep_d = 1'b1;
        end
        // wake request or software leaving sleep both end it
        if (sleep_q && (wake_i || !nap_i)) begin
            sleep_d = 1'b0;
            ost_d = 6'(OST_CYC); // crystal clock assumed, so start-up runs on every exit
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            sleep_q <= 1'b0;
            ost_q <= 6'h00;
            nap_q <= 1'b0;
        end else begin
            sleep_q <= sleep_d;
            ost_q <= ost_d;
            nap_q <= nap_i;
        end
    end
    assign sleep_o = sleep_q;
    assign ost_o = (ost_q != 6'h00);
endmodule : wdtu_core_model

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic       clock_i, rst_b_i, wr_i, rd_i, clear_watchdog_instr_i, osc_fail_i;
    logic       sleep_i, osc_startup_timer_i, wdt_reset_o, wake_o, nap, r, w;
    logic [1:0] wdt_mode_cfg_i;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [4:0] ps;
    logic       exp_f, slp_f, act_f;
    int         n_mismatch, samples_checked;

    wdtu_watchdog #(.TICK_CYCLES(4)) dut_u (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .wdt_mode_cfg_i, .sleep_i, .clear_watchdog_instr_i, .osc_fail_i,
        .osc_startup_timer_i, .wdt_reset_o, .wake_o, .wdt_expired_flag_o(exp_f),
        .sleep_entered_flag_o(slp_f), .wdt_active_o(act_f));
    wdtu_core_model core_u (.clock_i, .rst_b_i, .nap_i(nap), .wake_i(wake_o),
        .sleep_o(sleep_i), .ost_o(osc_startup_timer_i));

    always #5 clock_i = ~clock_i;

    function automatic logic [7:0] ctrl_val(input logic [4:0] p, input logic en);
        return {2'h0, p, en};
    endfunction : ctrl_val

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rdata", e, rdata_o);
    endtask : rd_reg

    task automatic pulse_clr();
        @(posedge clock_i);
        clear_watchdog_instr_i <= 1'b1;
        @(posedge clock_i);
        clear_watchdog_instr_i <= 1'b0;
    endtask : pulse_clr

    // or of both time-out pulses over n cycles
    task automatic watch(input int n);
        r = 1'b0;
        w = 1'b0;
        repeat (n) begin
            @(posedge clock_i);
            #1;
            r = r | wdt_reset_o;
            w = w | wake_o;
        end
    endtask : watch

    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    initial begin
        void'($urandom(58145));
        {clock_i, rst_b_i, wr_i, rd_i, clear_watchdog_instr_i, osc_fail_i, nap} = '0;
        {addr_i, wdata_i} = '0;
        wdt_mode_cfg_i = 2'h3;
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd_reg(8'h00, ctrl_val(5'h0b, 1'b0));
        rd_reg(8'h04, 8'h04);
        chk("flags", 8'h04, {act_f, slp_f, exp_f});
        rd_reg(8'h08, 8'h00);
        wr_reg(8'h04, 8'hff);
        rd_reg(8'h04, 8'h04);
        for (int i = 0; i < 4; i++) begin
            ps = (i == 3) ? 5'h03 : 5'($urandom_range(2));
            wr_reg(8'h00, ctrl_val(ps, 1'b0));
            pulse_clr();
            watch((4 << ps) - 2);
            chk("early", 8'h00, {r, w});
            watch(6);
            chk("awake_tmo", 8'h02, {r, w});
        end
        rd_reg(8'h04, 8'h05);
        chk("flags", 8'h05, {act_f, slp_f, exp_f});
        pulse_clr();
        rd_reg(8'h04, 8'h04);
        chk("flags", 8'h04, {act_f, slp_f, exp_f});
        // sleep first, so the first time-out at the short period is a wake
        nap <= 1'b1;
        wr_reg(8'h00, ctrl_val(5'h00, 1'b0));
        watch(12);
        chk("sleep_tmo", 8'h01, {r, w});
        watch(16);
        chk("startup", 8'h00, {r, w});
        rd_reg(8'h04, 8'h07);
        chk("flags", 8'h07, {act_f, slp_f, exp_f});
        nap <= 1'b0;
        wdt_mode_cfg_i <= 2'h2;
        watch(24);
        pulse_clr();
        nap <= 1'b1;
        watch(30);
        chk("mode_awake", 8'h00, {r, w});
        nap <= 1'b0;
        wdt_mode_cfg_i <= 2'h1;
        watch(30);
        chk("sw_off", 8'h00, {r, w});
        wr_reg(8'h00, ctrl_val(5'h00, 1'b1));
        watch(12);
        chk("sw_on", 8'h02, {r, w});
        wdt_mode_cfg_i <= 2'h0;
        watch(30);
        chk("mode_off", 8'h00, {r, w});
        wdt_mode_cfg_i <= 2'h3;
        osc_fail_i <= 1'b1;
        watch(30);
        chk("osc_fail", 8'h00, {r, w});
        // mid-run reset must bring the control register back to its defaults
        wr_reg(8'h00, ctrl_val(5'h12, 1'b1));
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd_reg(8'h00, ctrl_val(5'h0b, 1'b0));
        rd_reg(8'h04, 8'h04);
        chk("flags", 8'h04, {act_f, slp_f, exp_f});
        give_verdict();
    end

    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule : testbench
